// *** hdl/timer_common_defines.vh ***
`ifndef TIMER_COMMON_DEFINES_VH
`define TIMER_COMMON_DEFINES_VH

// ***************************************************
// register offsets inside one timer module window
// ***************************************************
`define OFS_CTRL0      4'h0
`define OFS_CTRL1      4'h1
`define OFS_CNT_LOW    4'h2
`define OFS_CNT_HIGH   4'h3
`define OFS_CMPA_LOW   4'h4
`define OFS_CMPA_HIGH  4'h5
`define OFS_CMPP_LOW   4'h6
`define OFS_CMPP_HIGH  4'h7
`define OFS_STATUS     4'h8
// module n window starts at n * 0x10
`define MOD_COUNT      2'h3
// shared pin control register
`define ADDR_PIN_CTRL  8'h30

// ***************************************************
// field positions
// ***************************************************
`define C0_ON          3
`define C0_CLK_HI      6
`define C0_CLK_LO      4
`define C1_MODE_HI     7
`define C1_MODE_LO     6
`define C1_ACT_HI      5
`define C1_ACT_LO      4
`define C1_INIT        3
`define C1_POL         2
`define C1_INV_PAIR    1
`define C1_CLR_ON_A    0
`define ST_FLAG_A      0
`define ST_FLAG_P      1
`define PC_PAIR_HI     7
`define PC_PAIR_LO     6

// ***************************************************
// codes and reset values
// ***************************************************
`define CLK_SYS_DIV4   3'h0
`define CLK_HIGH       3'h1
`define CLK_HIGH_DIV16 3'h2
`define CLK_HIGH_DIV64 3'h3
`define CLK_TIME_BASE  3'h4
`define CLK_RESERVED   3'h5
`define CLK_EXT_RISE   3'h6
`define CLK_EXT_FALL   3'h7
`define MODE_COMPARE   2'h0
`define MODE_PWM       2'h2
`define ACT_NONE       2'h0
`define ACT_LOW        2'h1
`define ACT_HIGH       2'h2
`define ACT_TOGGLE     2'h3
`define PAIR_BOTH      2'h3
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define DEAD_TIME_NS   160
`define CLK_PERIOD_NS  40

`endif

// *** hdl/timer_common_pin_and_access.v ***
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_common_defines.vh"

module timer_common_pin_and_access #(
  parameter DEAD_CYCLES = (`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] address,
  input  wire [7:0] writeData,
  input  wire       writeStrobe,
  input  wire       readStrobe,
  output reg  [7:0] readData,
  input  wire [2:0] timerExtClockPin,
  input  wire       timeBaseClock,
  output wire [2:0] extClockRouted,
  output wire [5:0] timerOutputPin,
  output wire [5:0] timerOutputEn,
  output reg        highSideDriverPin,
  output wire       highSideDriverEn,
  output reg        lowSideDriverPin,
  output wire       lowSideDriverEn,
  output wire       deadTimeActive,
  output wire [2:0] compareAReq,
  output wire [2:0] comparePReq
);

  // ***************************************************
  // storage
  // ***************************************************
  reg  [7:0]  ctrl0_reg [0:2];       // clock select, on bit
  reg  [7:0]  ctrl1_reg [0:2];       // mode, action, polarity
  reg  [15:0] count_reg [0:2];       // counters, cleared on switch-on and on match
  reg  [15:0] cmpA_reg  [0:2];       // comparator A values
  reg  [15:0] cmpP_reg  [0:2];       // comparator P values
  reg  [2:0]  flagA_reg;             // sticky compare A flags
  reg  [2:0]  flagP_reg;             // sticky compare P flags
  reg  [2:0]  outState_reg;          // compare/pwm output level
  reg  [2:0]  onPrev_reg;            // on bit delayed, edge find
  reg  [7:0]  holdBuf_reg;           // shared low byte buffer
  reg  [7:0]  pinCtrl_reg;           // timer_pin_control
  reg  [5:0]  preDiv_reg;            // prescaler for /4 /16 /64
  reg  [2:0]  extSync1_reg;          // ext clock first stage
  reg  [2:0]  extSync2_reg;          // ext clock second stage
  reg  [2:0]  extPrev_reg;           // ext clock edge history
  reg         tbSync1_reg;           // time base first stage
  reg         tbSync2_reg;           // time base second stage
  reg         tbPrev_reg;            // time base edge history
  reg  [7:0]  deadCnt_reg;           // dead time remaining
  reg         srcPrev_reg;           // driver source history
  reg  [7:0]  readData_next;         // read mux result

  // ***************************************************
  // helpers
  // ***************************************************
  // module index of an address, 3 means no module
  // only the bottom quarter of the map holds module windows
  function [1:0] modOf;
    input [7:0] addr;
    begin
      if (addr[7:6] == 2'h0 && addr[5:4] != `MOD_COUNT) begin
        modOf = addr[5:4];
      end else begin
        modOf = `MOD_COUNT;
      end
    end
  endfunction

  // apply a compare match action to a level
  // no action keeps the level; the match still sets its flag
  function applyAct;
    input [1:0] act;
    input       level;
    begin
      case (act)
        `ACT_LOW:    applyAct = 1'b0;
        `ACT_HIGH:   applyAct = 1'b1;
        `ACT_TOGGLE: applyAct = ~level;
        default:     applyAct = level;
      endcase
    end
  endfunction

  wire [1:0] busMod = modOf(address);   // addressed module
  wire [3:0] busOfs = address[3:0];     // offset in window
  wire       busHit = (busMod != `MOD_COUNT);

  // ***************************************************
  // clock tick selection
  // ***************************************************
  reg  [2:0] tick;       // one counter step this cycle
  reg  [2:0] matchA;     // compare A match on a step
  reg  [2:0] matchP;     // compare P match on a step
  reg  [2:0] wrHere;     // write aimed at each module
  reg  [2:0] clrOnA;     // counter clears on A instead of P
  // edges come from the second stage history, never the first
  wire [2:0] extRise = extSync2_reg & ~extPrev_reg;
  wire [2:0] extFall = ~extSync2_reg & extPrev_reg;
  wire       tbRise  = tbSync2_reg & ~tbPrev_reg;
  integer    k;

  // per module tick, matches only when counter steps
  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      case (ctrl0_reg[k][`C0_CLK_HI:`C0_CLK_LO])
        `CLK_SYS_DIV4:   tick[k] = (preDiv_reg[1:0] == 2'h3);
        `CLK_HIGH:       tick[k] = 1'b1;
        `CLK_HIGH_DIV16: tick[k] = (preDiv_reg[3:0] == 4'hf);
        `CLK_HIGH_DIV64: tick[k] = (preDiv_reg == 6'h3f);
        `CLK_TIME_BASE:  tick[k] = tbRise;
        // reserved stops the counter; module 1 runs at full rate
        `CLK_RESERVED:   tick[k] = (k == 1);
        `CLK_EXT_RISE:   tick[k] = extRise[k];
        `CLK_EXT_FALL:   tick[k] = extFall[k];
        default:         tick[k] = 1'b0;
      endcase
      // no step in the switch-on cycle: the stale count there
      // would raise a false match before the clear lands
      tick[k]   = tick[k] & ctrl0_reg[k][`C0_ON] & onPrev_reg[k];
      matchA[k] = tick[k] & (count_reg[k] == cmpA_reg[k]);
      matchP[k] = tick[k] & (count_reg[k] == cmpP_reg[k]);
      // per module write decode, shared by flags and registers
      wrHere[k] = writeStrobe && busHit && (busMod == k);
      clrOnA[k] = ctrl1_reg[k][`C1_CLR_ON_A];
    end
  end

  // external pin feeds the counter only when chosen
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gRoute
      assign extClockRouted[g] =
        (ctrl0_reg[g][`C0_CLK_HI:`C0_CLK_HI-1] == 2'h3);
    end
  endgenerate

  // ***************************************************
  // synchronisers and prescaler
  // ***************************************************
  // pins are asynchronous, two stages before any edge logic
  // the prescaler runs free, so a divided source takes its first
  // step anywhere inside one period after switch-on
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extSync1_reg <= 3'h0;
      extSync2_reg <= 3'h0;
      extPrev_reg  <= 3'h0;
      tbSync1_reg  <= 1'b0;
      tbSync2_reg  <= 1'b0;
      tbPrev_reg   <= 1'b0;
      preDiv_reg   <= 6'h00;
    end else begin
      extSync1_reg <= timerExtClockPin;
      extSync2_reg <= extSync1_reg;
      extPrev_reg  <= extSync2_reg;
      tbSync1_reg  <= timeBaseClock;
      tbSync2_reg  <= tbSync1_reg;
      tbPrev_reg   <= tbSync2_reg;
      preDiv_reg   <= preDiv_reg + 6'h01;
    end
  end

  // ***************************************************
  // timer state and register writes
  // ***************************************************
  integer i;

  // counters, outputs, flags and buffered writes share one process
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 3; i = i + 1) begin
        ctrl0_reg[i] <= `RST_BYTE;
        ctrl1_reg[i] <= `RST_BYTE;
        count_reg[i] <= `RST_WORD;
        cmpA_reg[i]  <= `RST_WORD;
        cmpP_reg[i]  <= `RST_WORD;
      end
      flagA_reg    <= 3'h0;
      flagP_reg    <= 3'h0;
      outState_reg <= 3'h0;
      onPrev_reg   <= 3'h0;
      holdBuf_reg  <= `RST_BYTE;
      pinCtrl_reg  <= `RST_BYTE;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        onPrev_reg[i] <= ctrl0_reg[i][`C0_ON];
        // counter: cleared on switch-on and on selected match
        if (ctrl0_reg[i][`C0_ON] && !onPrev_reg[i]) begin
          count_reg[i]    <= `RST_WORD;
          outState_reg[i] <= ctrl1_reg[i][`C1_INIT];
        end else if (tick[i]) begin
          if (clrOnA[i] ? matchA[i] : matchP[i]) begin
            count_reg[i] <= `RST_WORD;
          end else begin
            count_reg[i] <= count_reg[i] + 16'h0001;
          end
          case (ctrl1_reg[i][`C1_MODE_HI:`C1_MODE_LO])
            `MODE_COMPARE: begin
              if (matchA[i]) begin
                outState_reg[i] <=
                  applyAct(ctrl1_reg[i][`C1_ACT_HI:`C1_ACT_LO],
                           outState_reg[i]);
              end
            end
            `MODE_PWM: begin
              // high while count below duty, period set by clear
              outState_reg[i] <= (count_reg[i] < cmpA_reg[i]);
            end
            default: begin
              outState_reg[i] <= outState_reg[i];
            end
          endcase
        end
        // sticky flags, a new match beats a same-cycle clear
        // clear is write-one, so untouched bits never lose a request
        if (matchA[i]) begin
          flagA_reg[i] <= 1'b1;
        end else if (wrHere[i] && busOfs == `OFS_STATUS &&
                     writeData[`ST_FLAG_A]) begin
          flagA_reg[i] <= 1'b0;
        end
        if (matchP[i]) begin
          flagP_reg[i] <= 1'b1;
        end else if (wrHere[i] && busOfs == `OFS_STATUS &&
                     writeData[`ST_FLAG_P]) begin
          flagP_reg[i] <= 1'b0;
        end
        // register writes for this module
        // counter bytes are read only, so writes there fall through
        if (wrHere[i]) begin
          case (busOfs)
            `OFS_CTRL0:     ctrl0_reg[i] <= writeData;
            `OFS_CTRL1:     ctrl1_reg[i] <= writeData;
            `OFS_CMPA_HIGH: cmpA_reg[i]  <= {writeData, holdBuf_reg};
            `OFS_CMPP_HIGH: cmpP_reg[i]  <= {writeData, holdBuf_reg};
            default:        ctrl0_reg[i] <= ctrl0_reg[i];
          endcase
        end
      end
      // shared buffer: low writes park data, high reads capture low
      if (writeStrobe && busHit &&
          (busOfs == `OFS_CMPA_LOW || busOfs == `OFS_CMPP_LOW)) begin
        holdBuf_reg <= writeData;
      end else if (readStrobe && busHit) begin
        case (busOfs)
          `OFS_CNT_HIGH:  holdBuf_reg <= count_reg[busMod][7:0];
          `OFS_CMPA_HIGH: holdBuf_reg <= cmpA_reg[busMod][7:0];
          `OFS_CMPP_HIGH: holdBuf_reg <= cmpP_reg[busMod][7:0];
          default:        holdBuf_reg <= holdBuf_reg;
        endcase
      end
      // pin control sits outside every module window
      if (writeStrobe && address == `ADDR_PIN_CTRL) begin
        pinCtrl_reg <= writeData;
      end
    end
  end

  // ***************************************************
  // register reads
  // ***************************************************
  // low bytes never read live: pairs stay coherent across a carry
  always @* begin
    readData_next = 8'h00;
    if (address == `ADDR_PIN_CTRL) begin
      readData_next = pinCtrl_reg;
    end else if (busHit) begin
      case (busOfs)
        `OFS_CTRL0:     readData_next = ctrl0_reg[busMod];
        `OFS_CTRL1:     readData_next = ctrl1_reg[busMod];
        `OFS_CNT_LOW:   readData_next = holdBuf_reg;
        `OFS_CMPA_LOW:  readData_next = holdBuf_reg;
        `OFS_CMPP_LOW:  readData_next = holdBuf_reg;
        `OFS_CNT_HIGH:  readData_next = count_reg[busMod][15:8];
        `OFS_CMPA_HIGH: readData_next = cmpA_reg[busMod][15:8];
        `OFS_CMPP_HIGH: readData_next = cmpP_reg[busMod][15:8];
        `OFS_STATUS:    readData_next = {6'h00, flagP_reg[busMod],
                                         flagA_reg[busMod]};
        default:        readData_next = 8'h00;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  // zero outside the answer cycle keeps a stale byte off the bus
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      readData <= readData_next;
    end else begin
      readData <= 8'h00;
    end
  end

  assign compareAReq = flagA_reg;
  assign comparePReq = flagP_reg;

  // ***************************************************
  // output pins
  // ***************************************************
  generate
    for (g = 0; g < 3; g = g + 1) begin : gPins
      // polarity first, then the optional inversion of the second pin
      wire lvl = outState_reg[g] ^ ctrl1_reg[g][`C1_POL];
      assign timerOutputPin[2*g]   = lvl;
      assign timerOutputPin[2*g+1] =
        ctrl1_reg[g][`C1_INV_PAIR] ? ~lvl : lvl;
    end
  endgenerate

  // each bit of the low six hands one pin to the timer
  assign timerOutputEn = pinCtrl_reg[5:0];

  // ***************************************************
  // driver pair with dead time
  // ***************************************************
  wire [1:0] pairSel  = pinCtrl_reg[`PC_PAIR_HI:`PC_PAIR_LO];
  wire       drvSrc   = timerOutputPin[0];
  // enables follow the field directly; dead time needs both
  assign deadTimeActive   = (pairSel == `PAIR_BOTH);
  assign highSideDriverEn = pairSel[0];
  assign lowSideDriverEn  = pairSel[1];

  // both sides held off for a while after each source edge
  // only module 0 output 0 can feed the pair; the others cannot
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deadCnt_reg       <= 8'h00;
      srcPrev_reg       <= 1'b0;
      highSideDriverPin <= 1'b0;
      lowSideDriverPin  <= 1'b0;
    end else begin
      srcPrev_reg <= drvSrc;
      if (deadTimeActive && drvSrc != srcPrev_reg) begin
        deadCnt_reg <= DEAD_CYCLES[7:0];
      end else if (deadCnt_reg != 8'h00) begin
        deadCnt_reg <= deadCnt_reg - 8'h01;
      end
      if (deadTimeActive &&
          (drvSrc != srcPrev_reg || deadCnt_reg != 8'h00)) begin
        highSideDriverPin <= 1'b0;
        lowSideDriverPin  <= 1'b0;
      end else begin
        highSideDriverPin <= drvSrc;
        lowSideDriverPin  <= ~drvSrc;
      end
    end
  end

endmodule // timer_common_pin_and_access
`default_nettype wire

// *** bench/core_bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// processor core side of the register bus
// ****************************************
module core_bus_master (
  input  wire logic       clk,
  output var  logic [7:0] address,
  output var  logic [7:0] writeData,
  output var  logic       writeStrobe,
  output var  logic       readStrobe,
  input  wire logic [7:0] readData
);
  // idle bus from time zero, strobes low
  initial begin
    address     = 8'h00;
    writeData   = 8'h00;
    writeStrobe = 1'b0;
    readStrobe  = 1'b0;
  end
  // one-cycle write; callers put low byte before high byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
    #1;
  endtask
  // data stands only in the cycle after the strobe; high read first
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    address    <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask
endmodule // core_bus_master
`default_nettype wire

// *** bench/timer_pin_access_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port-level checker for the timer pin block
// ****************************************
module timer_pin_access_monitor #(
  parameter DEAD_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] address,
  input wire logic [7:0] writeData,
  input wire logic       writeStrobe,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic [2:0] extClockRouted,
  input wire logic [5:0] timerOutputEn,
  input wire logic       highSideDriverPin,
  input wire logic       highSideDriverEn,
  input wire logic       lowSideDriverPin,
  input wire logic       lowSideDriverEn,
  input wire logic       deadTimeActive,
  input wire logic [2:0] compareAReq,
  input wire logic [2:0] comparePReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire pcWr  = writeStrobe && address == 8'h30;  // pin control write
  wire stWr  = writeStrobe && address == 8'h08;  // module 0 status write
  wire c2Wr  = writeStrobe && address == 8'h20;  // module 2 ctrl0 write
  logic [3:0] gapCnt;                             // cycles since low driver was high
  // counter saturates so long idle spells do not wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gapCnt <= 4'h0;
    else if (lowSideDriverPin) gapCnt <= 4'h0;
    else if (gapCnt != 4'hf) gapCnt <= gapCnt + 4'h1;
  end
  chk_dead_follow: assert property (deadTimeActive == (highSideDriverEn && lowSideDriverEn))
    else $error("dead time not tied to driver pair code");
  chk_pin_enables: assert property (pcWr |=> timerOutputEn == $past(writeData[5:0]))
    else $error("output enables differ from written bits");
  chk_pair_field: assert property (pcWr |=> {lowSideDriverEn, highSideDriverEn} == $past(writeData[7:6]))
    else $error("driver enables differ from pair field");
  chk_enable_hold: assert property (!pcWr |=> $stable(timerOutputEn))
    else $error("output enables moved without a write");
  chk_no_overlap: assert property (!(highSideDriverPin && lowSideDriverPin))
    else $error("both drivers high together");
  chk_dead_gap: assert property (deadTimeActive && gapCnt < DEAD_CYCLES |-> !highSideDriverPin)
    else $error("high driver on inside the dead gap");
  chk_flag_a_hold: assert property (compareAReq[0] && !(stWr && writeData[0]) |=> compareAReq[0])
    else $error("compare A flag dropped without a clear");
  chk_flag_p_hold: assert property (comparePReq[0] && !(stWr && writeData[1]) |=> comparePReq[0])
    else $error("compare P flag dropped without a clear");
  chk_ext_select: assert property (c2Wr |=> extClockRouted[2] == ($past(writeData[6:5]) == 2'b11))
    else $error("external clock routing wrong for select code");
  chk_read_idle: assert property (!readStrobe |=> readData == 8'h00)
    else $error("read data present without a read");
endmodule // timer_pin_access_monitor
bind timer_common_pin_and_access timer_pin_access_monitor #(.DEAD_CYCLES(DEAD_CYCLES))
  timer_pin_access_monitor_inst (.clk, .reset_n, .address, .writeData, .writeStrobe,
  .readStrobe, .readData, .extClockRouted, .timerOutputEn, .highSideDriverPin,
  .highSideDriverEn, .lowSideDriverPin, .lowSideDriverEn, .deadTimeActive,
  .compareAReq, .comparePReq);
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, reset_n = 1'b0, tbClk = 1'b0;  // clock, reset, time base
  logic [2:0] extPin = 3'h0;                        // external clock pins
  logic [7:0] address, writeData, readData, d;
  logic writeStrobe, readStrobe, highSideDriverPin, highSideDriverEn;
  logic lowSideDriverPin, lowSideDriverEn, deadTimeActive;
  logic [2:0] extClockRouted, compareAReq, comparePReq;
  logic [5:0] timerOutputPin, timerOutputEn;
  logic [15:0] v;
  integer failures = 0, n_tests = 0, i, p;
  always #20 clk = ~clk;  // 25 MHz
  core_bus_master core_bus_master_inst (.clk, .address, .writeData, .writeStrobe,
    .readStrobe, .readData);
  timer_common_pin_and_access timer_common_pin_and_access_inst (.clk, .reset_n, .address,
    .writeData, .writeStrobe, .readStrobe, .readData, .timerExtClockPin(extPin),
    .timeBaseClock(tbClk), .extClockRouted, .timerOutputPin, .timerOutputEn,
    .highSideDriverPin, .highSideDriverEn, .lowSideDriverPin, .lowSideDriverEn,
    .deadTimeActive, .compareAReq, .comparePReq);
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    core_bus_master_inst.wr(a, x);
  endtask
  // high byte first so the low byte comes out of the buffer
  task automatic rdCnt(input logic [7:0] b, output logic [15:0] x);
    logic [7:0] h, l;
    core_bus_master_inst.rd(b + 8'h03, h);
    core_bus_master_inst.rd(b + 8'h02, l);
    x = {h, l};
  endtask
  // compare A at top, clear on A, so counting runs long
  task automatic prep(input logic [7:0] b);
    wr(b + 8'h04, 8'hff);
    wr(b + 8'h05, 8'hff);
    wr(b + 8'h01, 8'h01);
  endtask
  // bounded wait; a hang ends the run as a mismatch
  task automatic waitOn(input logic [1:0] s);
    integer n;
    for (n = 0; n < 400; n++) begin
      if (s == 0 && compareAReq[0] === 1'b1) break;
      if (s == 1 && timerOutputPin[0] === 1'b1) break;
      if (s == 2 && timerOutputPin[0] === 1'b0) break;
      @(posedge clk);
      #1;
    end
    if (n == 400) begin
      failures++;
      conclude();
    end
  endtask
  // k rises, k-1 falls; line left high
  task automatic pulse(input integer k, input logic tb);
    integer n;
    for (n = 0; n < k; n++) begin
      @(posedge clk) if (tb) tbClk <= 1'b1; else extPin[2] <= 1'b1;
      repeat (4) @(posedge clk);
      if (n < k - 1) begin
        if (tb) tbClk <= 1'b0; else extPin[2] <= 1'b0;
        repeat (4) @(posedge clk);
      end
    end
    #1;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    core_bus_master_inst.rd(8'h30, d); chk(d, 16'h0);
    for (p = 0; p < 4; p++) begin
      v[7:0] = {p[1:0], p[0] ? 6'h2a : 6'h15};
      wr(8'h30, v[7:0]);
      core_bus_master_inst.rd(8'h30, d); chk(d, v[7:0]);
      chk(deadTimeActive, p == 3);
      chk({lowSideDriverEn, highSideDriverEn}, p);
      chk(timerOutputEn, v[5:0]);
    end
    $display("pin control done");
    wr(8'h04, 8'h34);
    wr(8'h05, 8'h12);
    core_bus_master_inst.rd(8'h05, d); chk(d, 16'h12);
    wr(8'h04, 8'h56);
    core_bus_master_inst.rd(8'h05, d);
    core_bus_master_inst.rd(8'h04, d); chk(d, 16'h34);
    wr(8'hf0, 8'h5a);
    core_bus_master_inst.rd(8'hf0, d); chk(d, 16'h0);
    $display("byte access done");
    prep(8'h00);
    prep(8'h10);
    wr(8'h00, 8'h58);
    wr(8'h10, 8'h58);
    repeat (20) @(posedge clk);
    rdCnt(8'h00, v); chk(v, 16'h0);
    rdCnt(8'h10, v); chk(v != 0, 16'h1);
    for (p = 0; p < 4; p++) begin
      wr(8'h00, 8'h00);
      wr(8'h00, {1'b0, p[2:0], 4'h8});
      repeat (140) @(posedge clk);
      rdCnt(8'h00, v); chk(v != 0, 16'h1);
    end
    prep(8'h20);
    for (p = 6; p < 8; p++) begin
      wr(8'h20, {1'b0, p[2:0], 4'h8});
      chk(extClockRouted[2], 16'h1);
      pulse(5, 1'b0);
      rdCnt(8'h20, v); chk(v, p == 6 ? 16'h5 : 16'h4);
      @(posedge clk) extPin[2] <= 1'b0;
      wr(8'h20, 8'h00);
      chk(extClockRouted[2], 16'h0);
    end
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h48);
    pulse(3, 1'b1);
    rdCnt(8'h00, v); chk(v, 16'h3);
    @(posedge clk) tbClk <= 1'b0;
    $display("clock select done");
    wr(8'h30, 8'h01);
    for (p = 1; p < 4; p++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h03);
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h02);
      wr(8'h07, 8'h00);
      wr(8'h01, {2'b00, p[1:0], p == 1, 3'b001});
      wr(8'h08, 8'h03);
      wr(8'h00, 8'h18);
      waitOn(2'd0);
      wr(8'h00, 8'h10);
      chk(timerOutputPin[0], p != 1);
      wr(8'h08, 8'h01);
      chk({comparePReq[0], compareAReq[0]}, 16'h2);
    end
    $display("compare match done");
    wr(8'h00, 8'h00);
    wr(8'h30, 8'hc1);
    wr(8'h04, 8'h0a);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h14);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h82);
    wr(8'h00, 8'h18);
    waitOn(2'd1);
    waitOn(2'd2);
    waitOn(2'd1);
    for (i = 0; i < 40 && timerOutputPin[0] === 1'b1; i++) @(posedge clk) #1;
    chk(i[15:0], 16'ha);
    chk(timerOutputPin[1], 16'h1);
    for (p = 0; p < 40 && timerOutputPin[0] === 1'b0; p++) @(posedge clk) #1;
    chk(p[15:0], 16'hb);
    repeat (100) @(posedge clk);
    chk(deadTimeActive, 16'h1);
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    core_bus_master_inst.rd(8'h30, d); chk(d, 16'h0);
    $display("pwm and dead time done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
